/* File: rrsba_alu.sv */
// Rotate-right and subtract-with-borrow datapath slice with a Wishbone register port
//
// Overview of operation
// RULE1 - Rotate of the memory byte right by one, bit 0 wrapping to bit 7, written back, flags kept.
// RULE2 - Same rotate of the memory byte loaded into the work register, memory and flags kept.
// RULE3 - Nine-bit rotate of memory byte and carry, old carry to bit 7, bit 0 to carry, to memory.
// RULE4 - Same nine-bit rotate with the byte into the work register, carry from old bit 0.
// RULE5 - Work register minus memory byte minus inverted carry goes to the work register.
// RULE6 - The same difference goes to the memory byte instead.
// RULE7 - On both subtracts carry is 0 for a negative result and 1 for zero or positive.
// RULE8 - Both subtracts update overflow, zero, nibble carry, carry, signed and chained-zero flags.
// RULE9 - Overflow is signed overflow, zero is an all-zero result, nibble carry is 1 when the low nibble does not borrow.
`timescale 1ns/100ps
`default_nettype none
module rrsba_alu
  import rrsba_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Memory write-back
  output logic                   mem_wr_o,
  output logic      [7:0]        mem_wdata_o
);
  import rrsba_pkg::*;

  // Refused at elaboration: the register offsets need five address bits
  if (ADDR_W < 5)
  begin
    $error("rrsba_alu: ADDR_W must be at least 5");
  end

  logic                  ack_q, ack_d;
  logic [31:0]           dat_q, dat_d;
  logic [7:0]            work_q, work_d;
  logic [7:0]            oper_q, oper_d;
  logic [RRSBA_ST_W-1:0] stat_q, stat_d;
  logic                  mwr_q, mwr_d;
  logic [7:0]            mwd_q, mwd_d;

  logic                  wr_acc;
  logic                  cmd_fire;
  logic [2:0]            cmd_op;
  logic [4:0]            ofs;
  logic [7:0]            sub_diff;
  logic                  sub_c, sub_ac, sub_ov, sub_z;
  logic [7:0]            rot_plain;
  logic [7:0]            rot_carry;

  // Byte offset of the access, upper address bits must be zero to hit a register
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] o);
    hit = (a == ADDR_W'(o));
  endfunction

  assign ofs      = adr_i[4:0];
  assign wr_acc   = cyc_i & stb_i & we_i & ack_q;
  assign cmd_op   = dat_i[2:0];
  assign cmd_fire = wr_acc & sel_i[0] & hit(adr_i, RRSBA_OFS_COMMAND) & (cmd_op <= RRSBA_OP_LAST);

  assign rot_plain = {oper_q[0], oper_q[7:1]};                  // [RULE1] [RULE2]
  assign rot_carry = {stat_q[RRSBA_ST_C], oper_q[7:1]};         // [RULE3] [RULE4]

  rrsba_sub_unit u_sub
  (
    .minuend_i       (work_q),
    .subtrahend_i    (oper_q),
    .carry_i         (stat_q[RRSBA_ST_C]),
    .diff_o          (sub_diff),
    .carry_o         (sub_c),
    .nibble_carry_o  (sub_ac),
    .signed_excess_o (sub_ov),
    .zero_o          (sub_z)
  );

  // Bus answer: ack one cycle after the request, dropped the cycle after
  always_comb
  begin
    ack_d = cyc_i & stb_i & ~ack_q;
    dat_d = 32'h0000_0000;
    if (ofs == RRSBA_OFS_WORK && hit(adr_i, RRSBA_OFS_WORK))
      dat_d = {24'h00_0000, work_q};
    else if (hit(adr_i, RRSBA_OFS_STATUS))
      dat_d = {26'h000_0000, stat_q};
    else if (hit(adr_i, RRSBA_OFS_OPERAND))
      dat_d = {24'h00_0000, oper_q};
    else
      dat_d = 32'h0000_0000;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // Datapath state: register writes and operation execution
  always_comb
  begin
    work_d = work_q;
    oper_d = oper_q;
    stat_d = stat_q;
    mwr_d  = 1'b0;
    mwd_d  = mwd_q;
    if (wr_acc && sel_i[0])
    begin
      if (hit(adr_i, RRSBA_OFS_WORK))
        work_d = dat_i[7:0];
      else if (hit(adr_i, RRSBA_OFS_STATUS))
        stat_d = dat_i[RRSBA_ST_W-1:0];
      else if (hit(adr_i, RRSBA_OFS_OPERAND))
        oper_d = dat_i[7:0];
    end
    if (cmd_fire)
    begin
      case (rrsba_op_t'(cmd_op))
        RRSBA_OP_ROTATE_RIGHT_MEM:
        begin
          oper_d = rot_plain;                                   // [RULE1]
          mwr_d  = 1'b1;
          mwd_d  = rot_plain;
        end
        RRSBA_OP_ROTATE_RIGHT_TO_WORK:
        begin
          work_d = rot_plain;                                   // [RULE2]
        end
        RRSBA_OP_ROTATE_RIGHT_THRU_BORROW_BIT:
        begin
          oper_d             = rot_carry;                       // [RULE3]
          stat_d[RRSBA_ST_C] = oper_q[0];
          mwr_d              = 1'b1;
          mwd_d              = rot_carry;
        end
        RRSBA_OP_ROTATE_RIGHT_THRU_BORROW_BIT_TO_WORK:
        begin
          work_d             = rot_carry;                       // [RULE4]
          stat_d[RRSBA_ST_C] = oper_q[0];
        end
        RRSBA_OP_SUBTRACT_WITH_BORROW_TO_WORK,
        RRSBA_OP_SUBTRACT_WITH_BORROW_TO_MEM:
        begin
          if (cmd_op == RRSBA_OP_SUBTRACT_WITH_BORROW_TO_WORK)
            work_d = sub_diff;                                  // [RULE5]
          else
          begin
            oper_d = sub_diff;                                  // [RULE6]
            mwr_d  = 1'b1;
            mwd_d  = sub_diff;
          end
          stat_d[RRSBA_ST_C]  = sub_c;                          // [RULE7] [RULE8]
          stat_d[RRSBA_ST_AC] = sub_ac;                         // [RULE8]
          stat_d[RRSBA_ST_Z]  = sub_z;                          // [RULE8]
          stat_d[RRSBA_ST_OV] = sub_ov;                         // [RULE8]
          stat_d[RRSBA_ST_SC] = sub_ov ^ sub_diff[7];           // [RULE8]
          stat_d[RRSBA_ST_CZ] = sub_z & stat_q[RRSBA_ST_Z];     // [RULE8]
        end
        default:
        begin
          mwr_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      work_q <= RRSBA_RST_WORK;
      oper_q <= RRSBA_RST_OPERAND;
      stat_q <= RRSBA_RST_STATUS;
      mwr_q  <= 1'b0;
      mwd_q  <= 8'h00;
    end
    else
    begin
      work_q <= work_d;
      oper_q <= oper_d;
      stat_q <= stat_d;
      mwr_q  <= mwr_d;
      mwd_q  <= mwd_d;
    end
  end

  assign dat_o       = dat_q;
  assign ack_o       = ack_q;
  assign mem_wr_o    = mwr_q;
  assign mem_wdata_o = mwd_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fire(logic [2:0] op);
    cmd_fire && (cmd_op == op);
  endsequence

  a_rot_mem_keep: assert property (s_fire(RRSBA_OP_ROTATE_RIGHT_MEM) |=> // [RULE1]
    oper_q == {$past(oper_q[0]), $past(oper_q[7:1])} && stat_q == $past(stat_q)
    && work_q == $past(work_q) && mem_wr_o && mem_wdata_o == oper_q)
    else $error("rotate to memory wrong");

  a_rot_work_keep: assert property (s_fire(RRSBA_OP_ROTATE_RIGHT_TO_WORK) |=> // [RULE2]
    work_q == {$past(oper_q[0]), $past(oper_q[7:1])} && oper_q == $past(oper_q)
    && stat_q == $past(stat_q) && !mem_wr_o)
    else $error("rotate to work register wrong");

  a_rotc_mem_ring: assert property (s_fire(RRSBA_OP_ROTATE_RIGHT_THRU_BORROW_BIT) |=> // [RULE3]
    {oper_q, stat_q[RRSBA_ST_C]} == {$past(stat_q[RRSBA_ST_C]), $past(oper_q)}
    && stat_q[RRSBA_ST_W-1:1] == $past(stat_q[RRSBA_ST_W-1:1]) && mem_wr_o)
    else $error("rotate through carry to memory wrong");

  a_rotc_work_ring: assert property ( // [RULE4]
    s_fire(RRSBA_OP_ROTATE_RIGHT_THRU_BORROW_BIT_TO_WORK) |=>
    {work_q, stat_q[RRSBA_ST_C]} == {$past(stat_q[RRSBA_ST_C]), $past(oper_q)}
    && oper_q == $past(oper_q) && !mem_wr_o)
    else $error("rotate through carry to work register wrong");

  a_sub_work_diff: assert property (s_fire(RRSBA_OP_SUBTRACT_WITH_BORROW_TO_WORK) |=> // [RULE5]
    work_q == 8'($past(work_q) - $past(oper_q) - {7'h00, ~$past(stat_q[RRSBA_ST_C])})
    && oper_q == $past(oper_q))
    else $error("subtract to work register wrong");

  a_sub_mem_diff: assert property (s_fire(RRSBA_OP_SUBTRACT_WITH_BORROW_TO_MEM) |=> // [RULE6]
    oper_q == 8'($past(work_q) - $past(oper_q) - {7'h00, ~$past(stat_q[RRSBA_ST_C])})
    && work_q == $past(work_q) && mem_wr_o && mem_wdata_o == oper_q ##1 !mem_wr_o)
    else $error("subtract to memory wrong");

  a_sub_carry_sign: assert property (cmd_fire && cmd_op[2] |=> // [RULE7]
    stat_q[RRSBA_ST_C] == ({1'b0, $past(work_q)} >=
      ({1'b0, $past(oper_q)} + {8'h00, ~$past(stat_q[RRSBA_ST_C])})))
    else $error("carry after subtract wrong");

  a_sub_flag_set: assert property (cmd_fire && cmd_op[2] |=> // [RULE8] [RULE9]
    stat_q[RRSBA_ST_Z] == ($past(sub_diff) == 8'h00)
    && stat_q[RRSBA_ST_OV] == (($past(work_q[7]) != $past(oper_q[7]))
      && ($past(sub_diff[7]) != $past(work_q[7])))
    && stat_q[RRSBA_ST_AC] == ({1'b0, $past(work_q[3:0])} >=
      ({1'b0, $past(oper_q[3:0])} + {4'h0, ~$past(stat_q[RRSBA_ST_C])}))
    && stat_q[RRSBA_ST_SC] == (stat_q[RRSBA_ST_OV] ^ $past(sub_diff[7]))
    && stat_q[RRSBA_ST_CZ] == (stat_q[RRSBA_ST_Z] && $past(stat_q[RRSBA_ST_Z])))
    else $error("subtract flags wrong");

endmodule
`default_nettype wire

/* File: rrsba_pkg.sv */
// Shared constants, register map and operation codes for the rotate/subtract slice
package rrsba_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [4:0] RRSBA_OFS_WORK    = 5'h00;
  localparam logic [4:0] RRSBA_OFS_STATUS  = 5'h04;
  localparam logic [4:0] RRSBA_OFS_OPERAND = 5'h08;
  localparam logic [4:0] RRSBA_OFS_COMMAND = 5'h0c;

  // Status register field positions
  localparam int RRSBA_ST_C  = 0;
  localparam int RRSBA_ST_AC = 1;
  localparam int RRSBA_ST_Z  = 2;
  localparam int RRSBA_ST_OV = 3;
  localparam int RRSBA_ST_SC = 4;
  localparam int RRSBA_ST_CZ = 5;
  localparam int RRSBA_ST_W  = 6;

  // Reset values
  localparam logic [7:0]          RRSBA_RST_WORK    = 8'h00;
  localparam logic [7:0]          RRSBA_RST_OPERAND = 8'h00;
  localparam logic [RRSBA_ST_W-1:0] RRSBA_RST_STATUS = 6'h00;

  // Operation codes written to the command register
  typedef enum logic [2:0] {
    RRSBA_OP_ROTATE_RIGHT_MEM                     = 3'b000,
    RRSBA_OP_ROTATE_RIGHT_TO_WORK                 = 3'b001,
    RRSBA_OP_ROTATE_RIGHT_THRU_BORROW_BIT         = 3'b010,
    RRSBA_OP_ROTATE_RIGHT_THRU_BORROW_BIT_TO_WORK = 3'b011,
    RRSBA_OP_SUBTRACT_WITH_BORROW_TO_WORK         = 3'b100,
    RRSBA_OP_SUBTRACT_WITH_BORROW_TO_MEM          = 3'b101
  } rrsba_op_t;

  localparam logic [2:0] RRSBA_OP_LAST = 3'b101;

endpackage

/* File: rrsba_sub_unit.sv */
// Eight-bit subtract with inverted-carry borrow and its arithmetic flags
`timescale 1ns/100ps
`default_nettype none
module rrsba_sub_unit
(
  // Operands
  input  wire logic [7:0] minuend_i,
  input  wire logic [7:0] subtrahend_i,
  input  wire logic       carry_i,
  // Result and flags
  output logic      [7:0] diff_o,
  output logic            carry_o,
  output logic            nibble_carry_o,
  output logic            signed_excess_o,
  output logic            zero_o
);

  logic [8:0] full;
  logic [4:0] low;
  logic [8:0] bin9;
  logic [4:0] bin5;

  always_comb
  begin
    bin9 = {8'h00, ~carry_i};
    bin5 = {4'h0, ~carry_i};
    full = {1'b0, minuend_i} - {1'b0, subtrahend_i} - bin9;                   // [RULE5]
    low  = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]} - bin5;
    diff_o          = full[7:0];
    carry_o         = ~full[8];                                                // [RULE7]
    nibble_carry_o  = ~low[4];                                                 // [RULE9]
    signed_excess_o = (minuend_i[7] ^ subtrahend_i[7]) & (minuend_i[7] ^ full[7]); // [RULE9]
    zero_o          = (full[7:0] == 8'h00);                                    // [RULE9]
  end

endmodule
`default_nettype wire

/* File: test_rotate_right_subtract_borrow_alu.sv */
// Self-checking bench for the rotate and subtract-with-borrow slice
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module test_rotate_right_subtract_borrow_alu;
  import rrsba_pkg::*;
  typedef struct packed {logic [2:0] op; logic [7:0] w; logic [7:0] m; logic [5:0] st;
                         logic xw; logic [7:0] xa; logic [7:0] xm; logic [5:0] xs;} rrsba_row_t;
  localparam logic [7:0] A_W = {3'h0, RRSBA_OFS_WORK};
  localparam logic [7:0] A_S = {3'h0, RRSBA_OFS_STATUS};
  localparam logic [7:0] A_O = {3'h0, RRSBA_OFS_OPERAND};
  localparam logic [7:0] A_C = {3'h0, RRSBA_OFS_COMMAND};
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, mem_wr_o;
  logic [7:0]  adr_i, mem_wdata_o;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rdv;
  logic [22:0] e;
  int          err_total, checks_done;
  // Op, work, memory byte, status, then expected write-back, work, memory byte, status
  rrsba_row_t rows [12] = '{
    '{3'h0, 8'h00, 8'h81, 6'h3f, 1'b1, 8'h00, 8'hc0, 6'h3f},
    '{3'h1, 8'h55, 8'h01, 6'h15, 1'b0, 8'h80, 8'h01, 6'h15},
    '{3'h2, 8'h00, 8'h01, 6'h00, 1'b1, 8'h00, 8'h00, 6'h01},
    '{3'h2, 8'h00, 8'h80, 6'h01, 1'b1, 8'h00, 8'hc0, 6'h00},
    '{3'h3, 8'haa, 8'h03, 6'h01, 1'b0, 8'h81, 8'h03, 6'h01},
    '{3'h3, 8'h11, 8'hfe, 6'h3e, 1'b0, 8'h7f, 8'hfe, 6'h3e},
    '{3'h4, 8'h05, 8'h05, 6'h05, 1'b0, 8'h00, 8'h05, 6'h27},
    '{3'h4, 8'h05, 8'h04, 6'h00, 1'b0, 8'h00, 8'h04, 6'h07},
    '{3'h4, 8'h80, 8'h01, 6'h01, 1'b0, 8'h7f, 8'h01, 6'h19},
    '{3'h4, 8'h03, 8'h05, 6'h01, 1'b0, 8'hfe, 8'h05, 6'h10},
    '{3'h5, 8'h7f, 8'hff, 6'h00, 1'b1, 8'h7f, 8'h7f, 6'h00},
    '{3'h5, 8'h10, 8'h01, 6'h01, 1'b1, 8'h10, 8'h0f, 6'h01}};

  rrsba_alu #(.ADDR_W(8)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o));

  // One classic cycle; ends one edge after release so cyc/stb stay low a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rdv = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    wb(1'b0, a, 32'h0, 4'hf);
    `CHK(nm, ex, rdv)
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial
  begin
    #40000;
    err_total++;
    $display("Watchdog expired");
    summarize();
  end

  initial
  begin
    rst_i <= 1'b1; cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    adr_i <= 8'h00; sel_i <= 4'h0; dat_i <= 32'h0;
    err_total = 0; checks_done = 0;
    do_reset();
    `CHK("reset_mem_wr", 1'b0, mem_wr_o)
    `CHK("reset_mem_wdata", 8'h00, mem_wdata_o)
    rd(A_W, 32'h0, "reset_work");
    rd(A_O, 32'h0, "reset_operand");
    rd(A_S, 32'h0, "reset_status");
    $display("reset test done");
    for (int i = 0; i < 12; i++)
    begin
      e = {rows[i].xw, rows[i].xa, rows[i].xm, rows[i].xs};
      wb(1'b1, A_W, {24'h0, rows[i].w}, 4'hf);
      wb(1'b1, A_O, {24'h0, rows[i].m}, 4'hf);
      wb(1'b1, A_S, {26'h0, rows[i].st}, 4'hf);
      wb(1'b1, A_C, {29'h0, rows[i].op}, 4'hf);
      `CHK("mem_wr", e[22], mem_wr_o)
      if (e[22]) `CHK("mem_wdata", e[13:6], mem_wdata_o)
      @(posedge clk_i);
      `CHK("mem_wr_end", 1'b0, mem_wr_o)
      rd(A_W, {24'h0, e[21:14]}, "work");
      rd(A_O, {24'h0, e[13:6]}, "operand");
      rd(A_S, {26'h0, e[5:0]}, "status");
      $display("row %0d done", i);
    end
    // Negative difference clears carry, then the next rotate feeds it into bit 7
    wb(1'b1, A_W, 32'h00, 4'hf);
    wb(1'b1, A_O, 32'h01, 4'hf);
    wb(1'b1, A_S, 32'h01, 4'hf);
    wb(1'b1, A_C, 32'h4, 4'hf);
    rd(A_S, 32'h10, "chain_status");
    wb(1'b1, A_C, 32'h3, 4'hf);
    rd(A_W, 32'h00, "chain_work");
    rd(A_S, 32'h11, "chain_carry");
    $display("chain test done");
    wb(1'b1, 8'h10, 32'hff, 4'hf);
    rd(8'h10, 32'h0, "unmapped");
    wb(1'b1, A_W, 32'h5a, 4'hf);
    wb(1'b1, A_W, 32'ha5, 4'h0);
    rd(A_W, 32'h5a, "sel_off");
    wb(1'b1, A_C, 32'h6, 4'hf);
    `CHK("bad_cmd_wr", 1'b0, mem_wr_o)
    rd(A_W, 32'h5a, "bad_cmd");
    $display("refusal test done");
    do_reset();
    rd(A_W, 32'h0, "rerst_work");
    rd(A_S, 32'h0, "rerst_status");
    rd(A_O, 32'h0, "rerst_operand");
    `CHK("rerst_mem_wdata", 8'h00, mem_wdata_o)
    $display("mid-run reset test done");
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire
